// File: common/sd_irq_pkg.sv
// package for the sd host interrupt enable and status block
package sd_irq_pkg;

    // register byte offsets
    localparam logic [11:0] status_offset        = 12'h0230;
    localparam logic [11:0] status_enable_offset = 12'h0234;
    localparam logic [11:0] signal_enable_offset = 12'h0238;

    // reset values
    localparam logic [31:0] enable_reset = 32'h0000_0000;
    localparam logic [31:0] status_reset = 32'h0000_0000;

    // event bit positions
    localparam int cmd_done_bit        = 0;
    localparam int xfer_done_bit       = 1;
    localparam int wr_buffer_ready_bit = 4;
    localparam int rd_buffer_ready_bit = 5;
    localparam int fixed_zero_bit      = 15;
    localparam int cmd_timeout_bit     = 16;
    localparam int cmd_endbit_err_bit  = 18;
    localparam int data_timeout_bit    = 20;
    localparam int data_crc_err_bit    = 21;
    localparam int data_endbit_err_bit = 22;
    localparam int card_error_bit      = 28;
    localparam int bad_data_access_bit = 29;

    // writable positions of both enable registers and the status register
    localparam logic [31:0] writable_mask = 32'h3075_0033;
    localparam logic [31:0] error_half    = 32'hFFFF_0000;
    localparam logic [31:0] normal_half   = 32'h0000_FFFF;

    // apb request bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_type;

    // apb answer bundle
    typedef struct packed {
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } apb_rsp_type;

    // whole state of the block
    typedef struct packed {
        logic [31:0] status_en;
        logic [31:0] signal_en;
        logic [31:0] status;
        logic        irq;
        apb_rsp_type rsp;
    } state_type;

endpackage : sd_irq_pkg

// File: core/sd_host_interrupt_enables.sv
// sd host event status enables, signal enables, sticky status and interrupt
//
// Contract
// - signal-enable register at 238h, 32 bits, resets to zero.
// - signal-enable upper half gates error events, lower half normal events.
// - status-enable bit 18 permits command end-bit error to set status.
// - status-enable bit 16 permits command timeout to set status.
// - status-enable bits 5 and 4 permit buffer read and write ready.
// - status-enable bits 1 and 0 permit transfer and command completed.
// - bit 15 of both enable registers reads zero, ignores writes.
// - signal-enable bits 29,28,22,21,20 gate the data and card errors.
// - signal-enable bits 18 and 16 gate command end-bit and timeout errors.
// - signal-enable bits 5 and 4 gate buffer read and write ready.
// - signal-enable bits 1 and 0 gate transfer and command completed.
// - status-enable upper half permits error flags, lower half normal flags.
// - status-enable bits 29,28,22,21,20 permit the data and card errors.
// - status flags stay set until software writes one to them.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module sd_host_interrupt_enables
    import sd_irq_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // event pulses from the command and data engines
    input  wire logic [31:0] event_i,
    // status flags and interrupt
    output logic      [31:0] status_o,
    output logic             irq_o
);

    state_type   state_r;
    state_type   state_nxt;
    apb_req_type req;

    // keep only implemented enable positions
    function automatic logic [31:0] keep_writable(input logic [31:0] value);
        keep_writable = value & writable_mask;
    endfunction : keep_writable

    // bundle the bus inputs
    assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                   addr: paddr_i, wdata: pwdata_i};

    // next state of registers, flags, bus answer and interrupt
    always_comb begin
        logic        wr_acc;
        logic        rd_acc;
        logic [31:0] clr;
        logic [31:0] set;
        wr_acc    = 1'b0;
        rd_acc    = 1'b0;
        clr       = '0;
        set       = '0;
        state_nxt = state_r;
        state_nxt.rsp.ready  = 1'b0;
        state_nxt.rsp.slverr = 1'b0;
        state_nxt.rsp.rdata  = '0;
        // answer on the second access cycle, one wait state
        if (req.sel && req.enable && !state_r.rsp.ready) begin
            wr_acc = req.write;
            rd_acc = !req.write;
            state_nxt.rsp.ready = 1'b1;
        end
        if (req.addr == signal_enable_offset) begin
            if (wr_acc) begin
                state_nxt.signal_en = keep_writable(req.wdata);
            end
            state_nxt.rsp.rdata = rd_acc ? state_r.signal_en : '0;
        end else if (req.addr == status_enable_offset) begin
            if (wr_acc) begin
                state_nxt.status_en = keep_writable(req.wdata);
            end
            state_nxt.rsp.rdata = rd_acc ? state_r.status_en : '0;
        end else if (req.addr == status_offset) begin
            if (wr_acc) begin
                clr = keep_writable(req.wdata);
            end
            state_nxt.rsp.rdata = rd_acc ? state_r.status : '0;
        end else begin
            state_nxt.rsp.slverr = rd_acc | wr_acc;
        end
        // events reach status only where status-enabled
        set = event_i & state_r.status_en & writable_mask;
        // set wins over a clear in the same cycle
        state_nxt.status = (state_r.status & ~clr) | set;
        // error half and normal half both gated by signal enables
        state_nxt.irq = |((state_nxt.status & state_r.signal_en & error_half)
                        | (state_nxt.status & state_r.signal_en & normal_half));
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r.status_en <= enable_reset;
            state_r.signal_en <= enable_reset;
            state_r.status    <= status_reset;
            state_r.irq       <= 1'b0;
            state_r.rsp       <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs from flops
    assign prdata_o  = state_r.rsp.rdata;
    assign pready_o  = state_r.rsp.ready;
    assign pslverr_o = state_r.rsp.slverr;
    assign status_o  = state_r.status;
    assign irq_o     = state_r.irq;

    // masked timeout never sets its flag
    a_timeout_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[cmd_timeout_bit] && !state_r.status[cmd_timeout_bit])
        |=> !state_r.status[cmd_timeout_bit])
        else $error("masked command timeout set status");

    // masked end bit error never sets its flag
    a_endbit_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[cmd_endbit_err_bit] && !state_r.status[cmd_endbit_err_bit])
        |=> !state_r.status[cmd_endbit_err_bit])
        else $error("masked end bit error set status");

    // masked command done never sets its flag
    a_cmd_done_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[cmd_done_bit] && !state_r.status[cmd_done_bit])
        |=> !state_r.status[cmd_done_bit])
        else $error("masked command done set status");

    // masked transfer done never sets its flag
    a_xfer_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[xfer_done_bit] && !state_r.status[xfer_done_bit])
        |=> !state_r.status[xfer_done_bit])
        else $error("masked transfer done set status");

    // masked write ready never sets its flag
    a_wr_ready_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[wr_buffer_ready_bit] && !state_r.status[wr_buffer_ready_bit])
        |=> !state_r.status[wr_buffer_ready_bit])
        else $error("masked write ready set status");

    // masked read ready never sets its flag
    a_rd_ready_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[rd_buffer_ready_bit] && !state_r.status[rd_buffer_ready_bit])
        |=> !state_r.status[rd_buffer_ready_bit])
        else $error("masked read ready set status");

    // masked data timeout never sets its flag
    a_data_to_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[data_timeout_bit] && !state_r.status[data_timeout_bit])
        |=> !state_r.status[data_timeout_bit])
        else $error("masked data timeout set status");

    // masked data crc error never sets its flag
    a_data_crc_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[data_crc_err_bit] && !state_r.status[data_crc_err_bit])
        |=> !state_r.status[data_crc_err_bit])
        else $error("masked data crc error set status");

    // masked data end bit error never sets its flag
    a_data_eb_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[data_endbit_err_bit] && !state_r.status[data_endbit_err_bit])
        |=> !state_r.status[data_endbit_err_bit])
        else $error("masked data end bit error set status");

    // masked card error never sets its flag
    a_card_err_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[card_error_bit] && !state_r.status[card_error_bit])
        |=> !state_r.status[card_error_bit])
        else $error("masked card error set status");

    // masked bad access never sets its flag
    a_bad_acc_masked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (!state_r.status_en[bad_data_access_bit] && !state_r.status[bad_data_access_bit])
        |=> !state_r.status[bad_data_access_bit])
        else $error("masked bad access set status");

    // enabled transfer done is captured next cycle
    a_event_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[xfer_done_bit] && state_r.status_en[xfer_done_bit])
        |=> state_r.status[xfer_done_bit])
        else $error("enabled transfer done not captured");

    // enabled command done is captured next cycle
    a_cmd_done_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[cmd_done_bit] && state_r.status_en[cmd_done_bit])
        |=> state_r.status[cmd_done_bit])
        else $error("enabled command done not captured");

    // enabled write ready is captured next cycle
    a_wr_ready_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[wr_buffer_ready_bit] && state_r.status_en[wr_buffer_ready_bit])
        |=> state_r.status[wr_buffer_ready_bit])
        else $error("enabled write ready not captured");

    // enabled read ready is captured next cycle
    a_rd_ready_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[rd_buffer_ready_bit] && state_r.status_en[rd_buffer_ready_bit])
        |=> state_r.status[rd_buffer_ready_bit])
        else $error("enabled read ready not captured");

    // enabled command timeout is captured next cycle
    a_timeout_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[cmd_timeout_bit] && state_r.status_en[cmd_timeout_bit])
        |=> state_r.status[cmd_timeout_bit])
        else $error("enabled command timeout not captured");

    // enabled command end bit error is captured next cycle
    a_endbit_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[cmd_endbit_err_bit] && state_r.status_en[cmd_endbit_err_bit])
        |=> state_r.status[cmd_endbit_err_bit])
        else $error("enabled end bit error not captured");

    // enabled data timeout is captured next cycle
    a_data_to_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[data_timeout_bit] && state_r.status_en[data_timeout_bit])
        |=> state_r.status[data_timeout_bit])
        else $error("enabled data timeout not captured");

    // enabled card error is captured next cycle
    a_card_err_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[card_error_bit] && state_r.status_en[card_error_bit])
        |=> state_r.status[card_error_bit])
        else $error("enabled card error not captured");

    // enabled bad access is captured next cycle
    a_bad_acc_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (event_i[bad_data_access_bit] && state_r.status_en[bad_data_access_bit])
        |=> state_r.status[bad_data_access_bit])
        else $error("enabled bad access not captured");

    // flag holds without a one written
    a_flag_sticky: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r.status[cmd_done_bit] && !(psel_i && penable_i && pwrite_i))
        |=> state_r.status[cmd_done_bit])
        else $error("status flag dropped without clear");

    // fixed bit always zero
    a_bit15_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !state_r.signal_en[fixed_zero_bit] && !state_r.status_en[fixed_zero_bit])
        else $error("bit 15 of an enable register set");

    // reserved status positions stay zero
    a_status_reserved: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (status_o & ~writable_mask) == 32'h0000_0000)
        else $error("reserved status bit set");

    // interrupt follows enabled flags
    a_irq_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        irq_o == |(state_r.status & $past(state_r.signal_en)))
        else $error("interrupt does not match enabled status");

    // signal enable write lands
    a_sigen_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (psel_i && penable_i && pwrite_i && !pready_o && paddr_i == signal_enable_offset)
        |=> state_r.signal_en == ($past(pwdata_i) & writable_mask))
        else $error("signal enable write lost");

    // status enable write lands
    a_sten_write: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (psel_i && penable_i && pwrite_i && !pready_o && paddr_i == status_enable_offset)
        |=> state_r.status_en == ($past(pwdata_i) & writable_mask))
        else $error("status enable write lost");

    // no interrupt without an enabled flag or a new enabled event
    a_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (((state_r.status & state_r.signal_en) == 32'h0000_0000)
         && ((event_i & state_r.status_en) == 32'h0000_0000))
        |=> !irq_o)
        else $error("interrupt without enabled flag");

    // ready is a one-cycle answer
    a_ready_pulse: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");

    // error answer only with ready
    a_slverr_ready: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pslverr_o |-> pready_o)
        else $error("slave error without ready");

endmodule : sd_host_interrupt_enables

// File: test/tb_top.sv
// self-checking bench for the sd host interrupt enable block
`timescale 1ns/1ps
module tb_top;
    import sd_irq_pkg::*;
    logic        clock_i   = 0;
    logic        rst_n_i   = 0;
    logic        psel_i    = 0;
    logic        penable_i = 0;
    logic        pwrite_i  = 0;
    logic [11:0] paddr_i   = '0;
    logic [31:0] pwdata_i  = '0;
    logic [31:0] event_i   = '0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [31:0] status_o;
    logic        irq_o;
    logic [31:0] rd;
    logic        er;
    int          fail_count = 0;
    int          checks     = 0;
    int          bits[11]   = '{0, 1, 4, 5, 16, 18, 20, 21, 22, 28, 29};
    sd_host_interrupt_enables u_sd_host_interrupt_enables (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .event_i   (event_i),
        .status_o  (status_o),
        .irq_o     (irq_o)
    );
    // clock, 5 ns period
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic finish_test();
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, then one idle cycle
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask : apb
    // one-cycle event pulse, then let status and irq settle
    task automatic pulse(input logic [31:0] v);
        event_i <= v;
        @(posedge clock_i);
        event_i <= 32'h0000_0000;
        repeat (3) @(posedge clock_i);
    endtask : pulse
    task automatic t_reset();
        apb(signal_enable_offset, 1'b0, 32'h0000_0000); chk(rd, enable_reset);
        apb(status_enable_offset, 1'b0, 32'h0000_0000); chk(rd, enable_reset);
        chk({31'h0, irq_o}, 32'h0000_0000);
    endtask : t_reset
    task automatic t_access();
        apb(status_enable_offset, 1'b1, 32'hFFFF_FFFF);
        apb(signal_enable_offset, 1'b1, 32'hFFFF_FFFF);
        apb(status_enable_offset, 1'b0, 32'h0000_0000); chk(rd, 32'h3075_0033);
        apb(signal_enable_offset, 1'b0, 32'h0000_0000); chk(rd, 32'h3075_0033);
        apb(12'h23C, 1'b1, 32'h0000_0000); chk({31'h0, er}, 32'h0000_0001);
        apb(signal_enable_offset, 1'b0, 32'h0000_0000); chk(rd, 32'h3075_0033);
    endtask : t_access
    task automatic t_gate();
        apb(status_enable_offset, 1'b1, 32'h0000_0000);
        pulse(32'hFFFF_FFFF); chk(status_o, 32'h0000_0000);
        apb(status_enable_offset, 1'b1, 32'hFFFF_FFFF);
        pulse(32'hFFFF_FFFF); chk(status_o, 32'h3075_0033);
        chk({31'h0, irq_o}, 32'h0000_0001);
        apb(signal_enable_offset, 1'b1, 32'hCF8A_FFCC);
        @(posedge clock_i); chk({31'h0, irq_o}, 32'h0000_0000);
        // each enable bit alone must raise the interrupt
        foreach (bits[i]) begin
            apb(signal_enable_offset, 1'b1, 32'h0000_0001 << bits[i]);
            @(posedge clock_i); chk({31'h0, irq_o}, 32'h0000_0001);
        end
    endtask : t_gate
    task automatic t_clear();
        apb(status_offset, 1'b1, 32'h0000_0000);
        apb(status_offset, 1'b0, 32'h0000_0000); chk(rd, 32'h3075_0033);
        apb(status_offset, 1'b1, 32'h2000_0000);
        @(posedge clock_i); chk({31'h0, irq_o}, 32'h0000_0000);
        apb(status_offset, 1'b1, 32'hFFFF_FFFF); chk(status_o, 32'h0000_0000);
    endtask : t_clear
    // watchdog
    initial begin
        repeat (5000) @(posedge clock_i);
        fail_count++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_access();
        t_gate();
        t_clear();
        finish_test();
    end
endmodule : tb_top
